// *** verilog/bfs_breaker_fail.v ***
// Breaker failure supervision with per-winding isolation blocking
//
// Summary of operation
// - Winding isolation active when isolator-open input and low current.
// - Isolation active blocks differential and REF trips of that winding.
// - REF of a winding blocked internally while its isolation active.
// - CT supervision blocked per current input of isolated winding.
// - Isolated winding inputs excluded from differential and bias sums.
// - No breaker failure start from general trip while isolation active.
// - Isolation trip needs definite-time overcurrent and isolation active.
// - Up to five independent breaker failure functions, own settings.
// - Each function has phase and optional earth undercurrent element.
// - Earth source measured neutral input or derived from phases.
// - More than 12 same-sign samples asserts zero crossing, blocks trips.
// - Initiation starts first timer; breaker open normally resets it.
// - Second timer starts with first; expiries give retrip, backtrip.
// - Each function drives own retrip and backtrip outputs.
// - Timers start from own protection trips or external trip input.
// - Reset by breaker open or protection reset needs undercurrent reset.
// - Current initiation resets only when all three phases undercurrent.
// - Non-current: reset with prot reset, poles open, or undercurrent only.
// - External: any enabled of trip reset, poles open, undercurrent only.
// - Undercurrent-only keeps latched reset state zero; zero crossing blocks.
`timescale 1ns/1ps
`include "bfs_map.vh"
module bfs_breaker_fail #(
  parameter NUM_BF   = 5,
  parameter NUM_WIND = 3,
  parameter NUM_CT   = 5,
  parameter SAMPLE_W = 16,
  parameter TIMER_W  = `BFS_TIMER_W
) (
  input  wire                         sys_clk,
  input  wire                         rst,
  input  wire                         sampleEn,
  // Winding isolation
  input  wire [NUM_WIND-1:0]          windingIsolatorOpenIn,
  input  wire [NUM_WIND-1:0]          windingLowCurrent,
  input  wire [NUM_WIND-1:0]          diffTripReqIn,
  input  wire [NUM_WIND-1:0]          refTripReqIn,
  input  wire [NUM_WIND-1:0]          dtOvercurrentIn,
  input  wire [NUM_CT*NUM_WIND-1:0]   ctWindingMap,
  input  wire [NUM_CT-1:0]            ctSupervisionAlarmIn,
  output reg  [NUM_WIND-1:0]          windingIsolationActive,
  output reg  [NUM_WIND-1:0]          diffTripOut,
  output reg  [NUM_WIND-1:0]          refTripOut,
  output reg  [NUM_WIND-1:0]          isolationTripOut,
  output reg  [NUM_CT-1:0]            ctSupervisionAlarmOut,
  output reg  [NUM_CT-1:0]            diffCalcIncludeOut,
  // Breaker failure, one set per function
  input  wire [NUM_BF-1:0]            bfEnable,
  input  wire [NUM_BF-1:0]            currentTripIn,
  input  wire [NUM_BF-1:0]            noncurrentTripIn,
  input  wire [NUM_BF-1:0]            externalTripIn,
  input  wire [NUM_BF-1:0]            generalTripIn,
  input  wire [NUM_BF*3-1:0]          phaseLowCurrent,
  input  wire [NUM_BF-1:0]            measNeutralLowCurrent,
  input  wire [NUM_BF-1:0]            derivNeutralLowCurrent,
  input  wire [NUM_BF-1:0]            earthUcEnable,
  input  wire [NUM_BF-1:0]            earthUcMeasured,
  input  wire [NUM_BF*3*SAMPLE_W-1:0] phaseSamples,
  input  wire [NUM_BF*SAMPLE_W-1:0]   measNeutralSamples,
  input  wire [NUM_BF*SAMPLE_W-1:0]   derivNeutralSamples,
  input  wire [NUM_BF-1:0]            breakerPolesOpen,
  input  wire [NUM_BF*2-1:0]          noncurrentInitResetSel,
  input  wire [NUM_BF*3-1:0]          externalInitResetSel,
  input  wire [NUM_BF*NUM_WIND-1:0]   bfWindingMap,
  input  wire [NUM_BF*TIMER_W-1:0]    retripDelay,
  input  wire [NUM_BF*TIMER_W-1:0]    backtripDelay,
  output reg  [NUM_BF-1:0]            retripOut,
  output reg  [NUM_BF-1:0]            backtripOut,
  output reg  [NUM_BF-1:0]            latchedResetState,
  output reg  [NUM_BF*4-1:0]          zeroCrossDetOut
);
  // =============================================================
  // Input synchronisers for pins from auxiliary contacts
  reg [NUM_WIND-1:0] isoOpenMeta_reg;
  reg [NUM_WIND-1:0] isoOpenSync_reg;
  reg [NUM_BF-1:0]   extTripMeta_reg;
  reg [NUM_BF-1:0]   extTripSync_reg;
  reg [NUM_BF-1:0]   polesMeta_reg;
  reg [NUM_BF-1:0]   polesSync_reg;

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      isoOpenMeta_reg <= {NUM_WIND{1'b0}};
      isoOpenSync_reg <= {NUM_WIND{1'b0}};
      extTripMeta_reg <= {NUM_BF{1'b0}};
      extTripSync_reg <= {NUM_BF{1'b0}};
      polesMeta_reg   <= {NUM_BF{1'b0}};
      polesSync_reg   <= {NUM_BF{1'b0}};
    end else begin
      isoOpenMeta_reg <= windingIsolatorOpenIn;
      isoOpenSync_reg <= isoOpenMeta_reg;
      extTripMeta_reg <= externalTripIn;
      extTripSync_reg <= extTripMeta_reg;
      polesMeta_reg   <= breakerPolesOpen;
      polesSync_reg   <= polesMeta_reg;
    end
  end

  // =============================================================
  // Winding isolation and blocking
  wire [NUM_WIND-1:0] isoActive;
  assign isoActive = isoOpenSync_reg & windingLowCurrent;

  reg [NUM_CT-1:0] ctBlocked;
  integer c;
  integer w;
  always @* begin
    ctBlocked = {NUM_CT{1'b0}};
    for (c = 0; c < NUM_CT; c = c + 1)
      for (w = 0; w < NUM_WIND; w = w + 1)
        if (ctWindingMap[c*NUM_WIND+w] && isoActive[w])
          ctBlocked[c] = 1'b1;
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      windingIsolationActive <= {NUM_WIND{1'b0}};
      diffTripOut            <= {NUM_WIND{1'b0}};
      refTripOut             <= {NUM_WIND{1'b0}};
      isolationTripOut       <= {NUM_WIND{1'b0}};
      ctSupervisionAlarmOut  <= {NUM_CT{1'b0}};
      diffCalcIncludeOut     <= {NUM_CT{1'b1}};
    end else begin
      windingIsolationActive <= isoActive;
      diffTripOut            <= diffTripReqIn & ~isoActive;
      refTripOut             <= refTripReqIn & ~isoActive;
      isolationTripOut       <= dtOvercurrentIn & isoActive;
      ctSupervisionAlarmOut  <= ctSupervisionAlarmIn & ~ctBlocked;
      diffCalcIncludeOut     <= ~ctBlocked;
    end
  end

  // =============================================================
  // Breaker failure functions, one generate instance each
  genvar b;
  genvar p;
  generate
    for (b = 0; b < NUM_BF; b = b + 1) begin : gBf
      wire [3:0]         zcd;
      wire [SAMPLE_W-1:0] nSample;
      wire               nLowCur;
      wire               allUc;
      wire               zcBlock;
      wire               isoHit;
      wire               genStart;
      wire               curStart;
      wire               nonStart;
      wire               extStart;
      wire [1:0]         nonSel;
      wire [2:0]         extSel;
      wire [TIMER_W-1:0] rDly;
      wire [TIMER_W-1:0] bDly;
      reg  [1:0]         initKind_reg;
      reg  [1:0]         initKind_next;
      reg  [TIMER_W-1:0] retripTimer_reg;
      reg  [TIMER_W-1:0] backtripTimer_reg;
      reg                resetCond;
      reg                nonPrev_reg;
      reg                extPrev_reg;

      assign nonSel = noncurrentInitResetSel[b*2 +: 2];
      assign extSel = externalInitResetSel[b*3 +: 3];
      assign rDly   = retripDelay[b*TIMER_W +: TIMER_W];
      assign bDly   = backtripDelay[b*TIMER_W +: TIMER_W];

      // Earth source selection, measured or derived
      assign nSample = earthUcMeasured[b] ?
                       measNeutralSamples[b*SAMPLE_W +: SAMPLE_W] :
                       derivNeutralSamples[b*SAMPLE_W +: SAMPLE_W];
      assign nLowCur = earthUcMeasured[b] ? measNeutralLowCurrent[b] :
                       derivNeutralLowCurrent[b];
      // Disabled earth element counts as always operated
      assign allUc = (&phaseLowCurrent[b*3 +: 3]) &
                     (nLowCur | ~earthUcEnable[b]);

      for (p = 0; p < 3; p = p + 1) begin : gPh
        bfs_zero_cross #(.SAMPLE_W(SAMPLE_W)) uZc (
          .sys_clk      (sys_clk),
          .rst          (rst),
          .sampleEn     (sampleEn),
          .sample       (phaseSamples[(b*3+p)*SAMPLE_W +: SAMPLE_W]),
          .zeroCrossDet (zcd[p])
        );
      end
      bfs_zero_cross #(.SAMPLE_W(SAMPLE_W)) uZcN (
        .sys_clk      (sys_clk),
        .rst          (rst),
        .sampleEn     (sampleEn),
        .sample       (nSample),
        .zeroCrossDet (zcd[3])
      );
      assign zcBlock = (|zcd[2:0]) | (zcd[3] & earthUcEnable[b]);

      // General trips do not start the function on an isolated winding
      assign isoHit   = |(bfWindingMap[b*NUM_WIND +: NUM_WIND] & isoActive);
      assign genStart = generalTripIn[b] & ~isoHit;
      assign curStart = currentTripIn[b] | genStart;
      assign nonStart = noncurrentTripIn[b];
      assign extStart = extTripSync_reg[b];

      always @* begin
        case (initKind_reg)
          `BFS_INIT_CURRENT:
            resetCond = &phaseLowCurrent[b*3 +: 3];
          `BFS_INIT_NONCURRENT: begin
            case (nonSel)
              `BFS_NONI_PROT_RESET: resetCond = allUc & ~nonStart;
              `BFS_NONI_POLES_OPEN: resetCond = allUc & polesSync_reg[b];
              `BFS_NONI_UC_ONLY:    resetCond = allUc;
              default:              resetCond = allUc;
            endcase
          end
          `BFS_INIT_EXTERNAL:
            resetCond = allUc &
              ((extSel[`BFS_EXT_TRIP_RESET] & ~extStart) |
               (extSel[`BFS_EXT_POLES_OPEN] & polesSync_reg[b]) |
               extSel[`BFS_EXT_UC_ONLY]);
          default:
            resetCond = 1'b0;
        endcase
      end

      // Current initiation takes priority when several start together
      always @* begin
        initKind_next = initKind_reg;
        if (!bfEnable[b])
          initKind_next = `BFS_INIT_NONE;
        else if (initKind_reg == `BFS_INIT_NONE) begin
          if (curStart)
            initKind_next = `BFS_INIT_CURRENT;
          else if (nonStart & ~nonPrev_reg)
            initKind_next = `BFS_INIT_NONCURRENT;
          else if (extStart & ~extPrev_reg)
            initKind_next = `BFS_INIT_EXTERNAL;
        end else if (resetCond)
          initKind_next = `BFS_INIT_NONE;
      end

      always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          initKind_reg         <= `BFS_INIT_NONE;
          retripTimer_reg      <= {TIMER_W{1'b0}};
          backtripTimer_reg    <= {TIMER_W{1'b0}};
          nonPrev_reg          <= 1'b0;
          extPrev_reg          <= 1'b0;
          retripOut[b]         <= 1'b0;
          backtripOut[b]       <= 1'b0;
          latchedResetState[b] <= 1'b0;
          zeroCrossDetOut[b*4 +: 4] <= 4'h0;
        end else begin
          initKind_reg <= initKind_next;
          nonPrev_reg  <= nonStart;
          extPrev_reg  <= extStart;
          zeroCrossDetOut[b*4 +: 4] <= zcd;
          // Undercurrent-only reset never latches a reset state
          latchedResetState[b] <= (initKind_reg != `BFS_INIT_NONE) &&
            !(initKind_reg == `BFS_INIT_NONCURRENT &&
              nonSel == `BFS_NONI_UC_ONLY) &&
            !(initKind_reg == `BFS_INIT_EXTERNAL &&
              extSel[`BFS_EXT_UC_ONLY]);
          if (initKind_next == `BFS_INIT_NONE) begin
            retripTimer_reg   <= {TIMER_W{1'b0}};
            backtripTimer_reg <= {TIMER_W{1'b0}};
            retripOut[b]      <= 1'b0;
            backtripOut[b]    <= 1'b0;
          end else if (sampleEn) begin
            // Both timers run from the same start instant
            if (retripTimer_reg != rDly)
              retripTimer_reg <= retripTimer_reg + 16'h0001;
            if (backtripTimer_reg != bDly)
              backtripTimer_reg <= backtripTimer_reg + 16'h0001;
            retripOut[b]   <= (retripTimer_reg == rDly) & ~zcBlock;
            backtripOut[b] <= (backtripTimer_reg == bDly) & ~zcBlock;
          end
        end
      end
    end
  endgenerate
  // NUM_BF sets the function count, five by default
endmodule

// *** verilog/bfs_map.vh ***
// Constants for the breaker failure and winding isolation block
`ifndef BFS_MAP_VH
`define BFS_MAP_VH
// Zero crossing: more than this many same-sign samples asserts detection
`define BFS_ZC_LIMIT          8'h0c
// Non-current reset selection codes
`define BFS_NONI_PROT_RESET   2'h0
`define BFS_NONI_POLES_OPEN   2'h1
`define BFS_NONI_UC_ONLY      2'h2
// External reset enable bit positions
`define BFS_EXT_TRIP_RESET    0
`define BFS_EXT_POLES_OPEN    1
`define BFS_EXT_UC_ONLY       2
// Initiation kinds
`define BFS_INIT_NONE         2'h0
`define BFS_INIT_CURRENT      2'h1
`define BFS_INIT_NONCURRENT   2'h2
`define BFS_INIT_EXTERNAL     2'h3
// Timer defaults in sample ticks
`define BFS_RETRIP_DEFAULT    16'h0014
`define BFS_BACKTRIP_DEFAULT  16'h0028
`define BFS_TIMER_W           16
`endif

// *** verilog/bfs_zero_cross.v ***
// Per-phase zero crossing detector on signed current samples
`timescale 1ns/1ps
`include "bfs_map.vh"
module bfs_zero_cross #(
  parameter SAMPLE_W = 16,
  parameter CNT_W    = 8
) (
  input  wire                sys_clk,
  input  wire                rst,
  input  wire                sampleEn,
  input  wire [SAMPLE_W-1:0] sample,
  output reg                 zeroCrossDet
);
  reg  [CNT_W-1:0] runCount_reg;
  reg              lastSign_reg;
  wire             isZero;
  wire             curSign;
  wire [CNT_W-1:0] limit;

  assign isZero  = (sample == {SAMPLE_W{1'b0}});
  assign curSign = sample[SAMPLE_W-1];
  assign limit   = `BFS_ZC_LIMIT;

  // =============================================================
  // Same-sign run counter
  // A zero sample breaks the run: it is neither above nor below zero
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      runCount_reg <= 8'h00;
      lastSign_reg <= 1'b0;
      zeroCrossDet <= 1'b0;
    end else if (sampleEn) begin
      lastSign_reg <= curSign;
      if (isZero) begin
        runCount_reg <= 8'h00;
        zeroCrossDet <= 1'b0;
      end else if (runCount_reg != 8'h00 && curSign != lastSign_reg) begin
        runCount_reg <= 8'h01;
        zeroCrossDet <= 1'b0;
      end else begin
        if (runCount_reg != {CNT_W{1'b1}})
          runCount_reg <= runCount_reg + 8'h01;
        zeroCrossDet <= (runCount_reg >= limit);
      end
    end
  end
endmodule

// *** test/bfs_partner.sv ***
// Far-side model: sample strobe and current waveform
`timescale 1ns/1ps
module bfs_partner (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        acMode,
  output reg         sampleEn,
  output reg  [15:0] sample
);
  reg [3:0] tick;
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tick <= 4'h0;
      sampleEn <= 1'b0;
      sample <= 16'h0000;
    end else begin
      tick <= tick + 4'h1;
      sampleEn <= (tick[1:0] == 2'h3);
      // In AC mode the sign flips every two samples, so same-sign runs stay short
      if (tick[1:0] == 2'h3)
        sample <= (!acMode || !tick[3]) ? 16'h0064 : 16'hff9c;
    end
  end
endmodule

// *** test/bfs_breaker_fail_chk.sv ***
// Port checker for the breaker failure block
`timescale 1ns/1ps
module bfs_breaker_fail_chk #(
  parameter NUM_BF   = 5,
  parameter NUM_WIND = 3
) (
  input wire                  sys_clk,
  input wire                  rst,
  input wire                  sampleEn,
  input wire [NUM_WIND-1:0]   windingIsolatorOpenIn,
  input wire [NUM_WIND-1:0]   windingLowCurrent,
  input wire [NUM_WIND-1:0]   dtOvercurrentIn,
  input wire [NUM_WIND-1:0]   windingIsolationActive,
  input wire [NUM_WIND-1:0]   diffTripOut,
  input wire [NUM_WIND-1:0]   refTripOut,
  input wire [NUM_WIND-1:0]   isolationTripOut,
  input wire [NUM_BF-1:0]     bfEnable,
  input wire [NUM_BF-1:0]     currentTripIn,
  input wire [NUM_BF-1:0]     generalTripIn,
  input wire [NUM_BF*3-1:0]   phaseLowCurrent,
  input wire [NUM_BF-1:0]     earthUcEnable,
  input wire [NUM_BF*2-1:0]   noncurrentInitResetSel,
  input wire [NUM_BF*3-1:0]   externalInitResetSel,
  input wire [NUM_BF-1:0]     retripOut,
  input wire [NUM_BF-1:0]     backtripOut,
  input wire [NUM_BF*4-1:0]   zeroCrossDetOut
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Pin path needs three edges of history before it can be judged
  reg [2:0] upCnt;
  always @(posedge sys_clk or posedge rst)
    if (rst) upCnt <= 3'h0;
    else if (upCnt != 3'h4) upCnt <= upCnt + 3'h1;
  sequence s_off;
    (!bfEnable[0] && !retripOut[0] && !backtripOut[0]) ##1 (!bfEnable[0])[*2];
  endsequence
  sequence s_ucReset;
    phaseLowCurrent[2:0] == 3'h7 && noncurrentInitResetSel[1:0] == 2'h2 &&
    externalInitResetSel[2:0] == 3'h4 && !earthUcEnable[0] &&
    !currentTripIn[0] && !generalTripIn[0];
  endsequence
  iso_active_a: assert property (upCnt == 3'h4 |->
    windingIsolationActive == ($past(windingIsolatorOpenIn, 3) &
    $past(windingLowCurrent))) else $error("isolation active wrong");
  diff_block_a: assert property (
    (diffTripOut & windingIsolationActive & $past(windingIsolationActive))
    == 3'h0) else $error("diff trip while isolated");
  ref_block_a: assert property (
    (refTripOut & windingIsolationActive & $past(windingIsolationActive))
    == 3'h0) else $error("ref trip while isolated");
  iso_trip_a: assert property ((isolationTripOut & ~($past(dtOvercurrentIn) &
    (windingIsolationActive | $past(windingIsolationActive)))) == 3'h0)
    else $error("isolation trip without cause");
  retrip_tick_a: assert property ($rose(retripOut[0]) |-> $past(sampleEn))
    else $error("retrip rose off a sample");
  backtrip_tick_a: assert property ($rose(backtripOut[0]) |-> $past(sampleEn))
    else $error("backtrip rose off a sample");
  zc_block_a: assert property ($rose(retripOut[0]) |->
    $past(zeroCrossDetOut[3:0]) == 4'h0) else $error("retrip despite zc");
  idle_off_a: assert property (s_off |-> !retripOut[0] && !backtripOut[0])
    else $error("disabled function tripped");
  uc_reset_a: assert property (s_ucReset |-> ##2
    !retripOut[0] && !backtripOut[0]) else $error("no reset on undercurrent");
endmodule

// *** test/bfs_breaker_fail_tb_top.sv ***
// Self-checking bench for the breaker failure block
`timescale 1ns/1ps
module bfs_breaker_fail_tb_top;
  reg sys_clk = 1'b0;
  reg rst = 1'b1;
  reg acMode = 1'b1;
  reg [2:0] isoIn = 3'h0, lcIn = 3'h0, reqIn = 3'h0, dtIn = 3'h0;
  reg [4:0] bfEn = 5'h1e, curTrip = 5'h00, ncTrip = 5'h00;
  reg [4:0] extTrip = 5'h00, genTrip = 5'h00, poles = 5'h00;
  reg [4:0] eEn = 5'h00, eMeas = 5'h00, mLc = 5'h00, dLc = 5'h00;
  reg [14:0] phLc = 15'h0000, extSel = 15'h7fff;
  reg [9:0] ncSel = 10'h000;
  reg [79:0] rtDly = {5{16'h0003}}, btDly = {5{16'h0006}};
  reg [17:0] rows [0:4];
  wire [2:0] act, diffO, refO, isoTrip;
  wire [4:0] ctO, incO, retrip, backtrip, latched, isoCt;
  wire [19:0] zc;
  wire sampleEn;
  wire [15:0] sample;
  integer err_count = 0, comparisons = 0, k, n, m;
  always #2.5 sys_clk = ~sys_clk;
  bfs_partner i_far (.sys_clk, .rst, .acMode, .sampleEn, .sample);
  bfs_breaker_fail i_dut (.sys_clk, .rst, .sampleEn,
    .windingIsolatorOpenIn(isoIn), .windingLowCurrent(lcIn),
    .diffTripReqIn(reqIn), .refTripReqIn(reqIn), .dtOvercurrentIn(dtIn),
    .ctWindingMap(15'h2311), .ctSupervisionAlarmIn(5'h1f),
    .windingIsolationActive(act), .diffTripOut(diffO), .refTripOut(refO),
    .isolationTripOut(isoTrip), .ctSupervisionAlarmOut(ctO),
    .diffCalcIncludeOut(incO), .bfEnable(bfEn), .currentTripIn(curTrip),
    .noncurrentTripIn(ncTrip), .externalTripIn(extTrip),
    .generalTripIn(genTrip), .phaseLowCurrent(phLc),
    .measNeutralLowCurrent(mLc), .derivNeutralLowCurrent(dLc),
    .earthUcEnable(eEn), .earthUcMeasured(eMeas),
    .phaseSamples({15{sample}}), .measNeutralSamples({5{sample}}),
    .derivNeutralSamples({5{sample}}), .breakerPolesOpen(poles),
    .noncurrentInitResetSel(ncSel), .externalInitResetSel(extSel),
    .bfWindingMap(15'h0001), .retripDelay(rtDly), .backtripDelay(btDly),
    .retripOut(retrip), .backtripOut(backtrip),
    .latchedResetState(latched), .zeroCrossDetOut(zc));
  // CT to winding map 0,1,2,0,1
  assign isoCt = {act[1], act[0], act[2], act[1], act[0]};
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task waitOut(input sel, input integer lim, output integer cnt);
    begin
      cnt = 0;
      while ((sel ? backtrip[0] : retrip[0]) !== 1'b1 && cnt < lim) begin
        @(negedge sys_clk);
        cnt = cnt + 1;
      end
    end
  endtask
  task step(input integer c);
    repeat (c) @(negedge sys_clk);
  endtask
  task summarize;
    begin
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // ==========================================================
  // Tests
  initial begin
    rows[0] = 18'h07fc0;
    rows[1] = 18'h38fc0;
    rows[2] = 18'h09fc9;
    rows[3] = 18'h37ab2;
    rows[4] = 18'h3f038;
    step(12);
    rst = 1'b0;
    step(1);
    chk({incO, retrip, backtrip, latched}, 20'hf8000);
    for (k = 0; k < 5; k = k + 1) begin
      {isoIn, lcIn, reqIn, dtIn} = rows[k][17:6];
      step(4);
      chk({act, isoTrip}, rows[k][5:0]);
      chk({diffO, refO}, {2{reqIn & ~rows[k][5:3]}});
      chk({ctO, incO}, {~isoCt, ~isoCt});
    end
    {isoIn, lcIn, reqIn, dtIn} = 12'h000;
    $display("test isolation table done");
    curTrip[0] = 1'b1;
    waitOut(0, 30, n);
    chk(n, 30);
    bfEn = 5'h1f;
    step(1);
    waitOut(0, 40, n);
    chk(n >= 12 && n <= 20, 1);
    chk(retrip[4:1], 0);
    waitOut(1, 40, m);
    chk(n + m >= 24 && n + m <= 32, 1);
    chk(zc[3:0], 0);
    curTrip[0] = 1'b0;
    phLc[2:0] = 3'h3;
    step(10);
    chk(retrip[0], 1);
    phLc[2:0] = 3'h7;
    step(3);
    chk({retrip[0], backtrip[0]}, 0);
    phLc = 15'h0000;
    acMode = 1'b0;
    rtDly[15:0] = 16'h0014;
    curTrip[0] = 1'b1;
    waitOut(0, 120, n);
    chk(n, 120);
    chk(zc[3:0], 4'hf);
    {curTrip, phLc, acMode, rtDly[15:0]} = {20'h07fff, 1'b1, 16'h0003};
    step(4);
    phLc = 15'h0000;
    $display("test timers done");
    // Isolator pin needs its two sync stages before the trip arrives
    {isoIn[0], lcIn[0]} = 2'h3;
    step(3);
    genTrip[0] = 1'b1;
    waitOut(0, 40, n);
    chk(n, 40);
    isoIn[0] = 1'b0;
    waitOut(0, 40, n);
    chk(n < 40, 1);
    {lcIn[0], genTrip[0], phLc, poles} = {2'h0, 15'h7fff, 5'h1f};
    step(6);
    {phLc, poles} = 20'h00000;
    $display("test general trip done");
    for (k = 0; k < 6; k = k + 1) begin
      ncSel[1:0] = 2'(k % 3);
      extSel[2:0] = 3'h1 << (k % 3);
      phLc[2:0] = 3'h7;
      if (k < 3) ncTrip[0] = 1'b1;
      else extTrip[0] = 1'b1;
      step(30);
      chk(retrip[0], k % 3 != 2);
      chk(latched[0], k % 3 != 2);
      {ncTrip[0], extTrip[0]} = 2'h0;
      step(6);
      chk(retrip[0], k % 3 == 1);
      poles[0] = 1'b1;
      step(6);
      chk({retrip[0], backtrip[0]}, 0);
      poles[0] = 1'b0;
      step(2);
    end
    $display("test reset options done");
    // Earth element enabled, measured input still carrying current
    {eEn[0], eMeas[0], mLc[0], dLc[0], ncTrip[0]} = 5'h1b;
    step(30);
    chk(retrip[0], 1);
    eMeas[0] = 1'b0;
    step(3);
    chk(retrip[0], 0);
    {ncTrip[0], eEn[0], phLc, curTrip[0]} = 18'h00001;
    waitOut(0, 40, n);
    chk(n < 40, 1);
    // Reset in mid-run while a function is active
    rst = 1'b1;
    step(2);
    chk({incO, retrip, backtrip, latched}, 20'hf8000);
    chk(zc, 20'h00000);
    rst = 1'b0;
    waitOut(0, 40, n);
    chk(n >= 12 && n <= 20, 1);
    {curTrip[0], phLc} = 16'h7fff;
    step(4);
    chk({retrip[0], backtrip[0]}, 0);
    $display("test earth and mid-run reset done");
    summarize;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    err_count = err_count + 1;
    $display("watchdog expired");
    summarize;
  end
endmodule
bind bfs_breaker_fail bfs_breaker_fail_chk #(.NUM_BF(NUM_BF),
  .NUM_WIND(NUM_WIND)) u_chk (.sys_clk, .rst, .sampleEn,
  .windingIsolatorOpenIn, .windingLowCurrent, .dtOvercurrentIn,
  .windingIsolationActive, .diffTripOut, .refTripOut, .isolationTripOut,
  .bfEnable, .currentTripIn, .generalTripIn, .phaseLowCurrent,
  .earthUcEnable, .noncurrentInitResetSel, .externalInitResetSel,
  .retripOut, .backtripOut, .zeroCrossDetOut);
